// ---- rtl/ppi_consts.vh ----
`ifndef PPI_CONSTS_VH
`define PPI_CONSTS_VH
// Behaviour
// - Each pin stores an output data bit driven while used as general output.
// - Written data is stored always, reaches pin only as general output.
// - Direction 0: data location reads the synchronized pin level.
// - Direction 1: data location reads the stored output data bit.
// - Direction bit picks input or output, ignored under peripheral control.
// - Input location always reads the synchronized pin level.
// - Drive strength select matters only while the pin is an output.
// - Pull enable matters only while the pin is an input.
// - Port A eight pins general purpose, lower four also serial interface.
// - Port C bit 1 die interrupt input with pull-down, bit 0 clock output.
// - Port C bit 0 clock output may use reduced drive.
// - Die interrupt synchronized; stop mode bypass delivers it asynchronously for wake-up.
// - Port D carries die data both ways, pull-downs on input pins.
// - Port D die data outputs may use reduced drive.
// - Port E pins are general purpose or used by the oscillator.
// - Reduced drive bit 1 gives one fifth strength, 0 full strength.
// - Port E pull-downs on after reset, forced off by oscillator, bit kept.
// - Debug pin pull-up on after reset, matters only while input.

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PPI_DATA_RST 8'h00
`define PPI_DIR_RST 8'h00
`define PPI_DBG_PU_RST 1'h1
`define PPI_PE_PD_RST 1'h1
`define PPI_RDRV_RST 1'h0

// ---------------------------------------------------------------
// Port widths and field positions
// ---------------------------------------------------------------
`define PPI_A_W 8
`define PPI_E_W 2
`define PPI_A_SPI_W 4
`define PPI_C_IRQ_BIT 1
`define PPI_C_CLK_BIT 0
`endif

// ---- rtl/ppi_port_pins.v ----
`include "ppi_consts.vh"

module ppi_port_pins (
   input wire CLOCK_I,
   input wire RESET_N_I,
   // Port A general purpose and serial peripheral
   input wire PORTA_DATA_WE_I,
   input wire [7:0] PORTA_DATA_WDATA_I,
   input wire PORTA_DIR_WE_I,
   input wire [7:0] PORTA_DIR_WDATA_I,
   input wire [3:0] SPI_EN_I,
   input wire [3:0] SPI_OUT_I,
   input wire [3:0] SPI_OE_I,
   input wire [7:0] PA_PIN_I,
   output reg [7:0] PA_PIN_O,
   output reg [7:0] PA_PIN_OE_O,
   output reg [7:0] PORTA_DATA_RD_O,
   output reg [7:0] PORTA_INPUT_RD_O,
   output reg [3:0] SPI_IN_O,
   // Port E general purpose and oscillator
   input wire PORTE_DATA_WE_I,
   input wire [1:0] PORTE_DATA_WDATA_I,
   input wire PORTE_DIR_WE_I,
   input wire [1:0] PORTE_DIR_WDATA_I,
   input wire OSC_ACTIVE_I,
   input wire [1:0] PE_PIN_I,
   output reg [1:0] PE_PIN_O,
   output reg [1:0] PE_PIN_OE_O,
   output reg [1:0] PE_PULLDOWN_O,
   output reg [1:0] PORTE_DATA_RD_O,
   output reg [1:0] PORTE_INPUT_RD_O,
   // Pull and drive control
   input wire PULL_WE_I,
   input wire DEBUG_PIN_PULLUP_ENABLE_I,
   input wire PORTE_PULLDOWN_ENABLE_I,
   input wire DRIVE_WE_I,
   input wire PORTC_REDUCED_DRIVE_I,
   input wire PORTD_REDUCED_DRIVE_I,
   output reg DEBUG_PIN_PULLUP_ENABLE_O,
   output reg PORTE_PULLDOWN_ENABLE_O,
   output reg PORTC_REDUCED_DRIVE_O,
   output reg PORTD_REDUCED_DRIVE_O,
   // Background debug pin
   input wire DBG_OE_I,
   output reg DBG_PULLUP_O,
   // Die-to-die interface on ports C and D
   input wire D2D_CLK_I,
   input wire PC1_PIN_I,
   input wire STOP_MODE_I,
   output reg PC0_PIN_O,
   output reg PC0_REDUCED_O,
   output reg PC1_PULLDOWN_O,
   output reg D2D_IRQ_SYNC_O,
   output wire D2D_IRQ_WAKE_O,
   input wire [7:0] D2D_DATA_OUT_I,
   input wire D2D_DATA_OE_I,
   input wire [7:0] PD_PIN_I,
   output reg [7:0] PD_PIN_O,
   output reg [7:0] PD_PIN_OE_O,
   output reg [7:0] PD_PULLDOWN_O,
   output reg PD_REDUCED_O,
   output reg [7:0] D2D_DATA_IN_O
);

   reg [7:0] pa_data;
   reg [7:0] pa_dir;
   reg [1:0] pe_data;
   reg [1:0] pe_dir;
   reg [7:0] pa_meta;
   reg [7:0] pa_sync;
   reg [1:0] pe_meta;
   reg [1:0] pe_sync;
   reg [7:0] pd_meta;
   reg [7:0] pd_sync;
   reg irq_meta;
   reg irq_sync;
   wire [7:0] pa_own;
   wire [7:0] pa_out;
   wire [7:0] pa_oe;

   // ---------------------------------------------------------------
   // Stored configuration
   // ---------------------------------------------------------------
   // Data is stored even while the pin is an input, so software can
   // preload it before turning the output on and avoid a glitch
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         pa_data <= `PPI_DATA_RST;
         pa_dir <= `PPI_DIR_RST;
         pe_data <= 2'h0;
         pe_dir <= 2'h0;
         DEBUG_PIN_PULLUP_ENABLE_O <= `PPI_DBG_PU_RST;
         PORTE_PULLDOWN_ENABLE_O <= `PPI_PE_PD_RST;
         PORTC_REDUCED_DRIVE_O <= `PPI_RDRV_RST;
         PORTD_REDUCED_DRIVE_O <= `PPI_RDRV_RST;
      end else begin
         if (PORTA_DATA_WE_I) begin
            pa_data <= PORTA_DATA_WDATA_I;
         end
         if (PORTA_DIR_WE_I) begin
            pa_dir <= PORTA_DIR_WDATA_I;
         end
         if (PORTE_DATA_WE_I) begin
            pe_data <= PORTE_DATA_WDATA_I;
         end
         if (PORTE_DIR_WE_I) begin
            pe_dir <= PORTE_DIR_WDATA_I;
         end
         if (PULL_WE_I) begin
            DEBUG_PIN_PULLUP_ENABLE_O <= DEBUG_PIN_PULLUP_ENABLE_I;
            PORTE_PULLDOWN_ENABLE_O <= PORTE_PULLDOWN_ENABLE_I;
         end
         if (DRIVE_WE_I) begin
            PORTC_REDUCED_DRIVE_O <= PORTC_REDUCED_DRIVE_I;
            PORTD_REDUCED_DRIVE_O <= PORTD_REDUCED_DRIVE_I;
         end
      end
   end

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   // Two stages on every pin; only the second stage feeds logic
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         pa_meta <= 8'h00;
         pa_sync <= 8'h00;
         pe_meta <= 2'h0;
         pe_sync <= 2'h0;
         pd_meta <= 8'h00;
         pd_sync <= 8'h00;
         irq_meta <= 1'b0;
         irq_sync <= 1'b0;
      end else begin
         pa_meta <= PA_PIN_I;
         pa_sync <= pa_meta;
         pe_meta <= PE_PIN_I;
         pe_sync <= pe_meta;
         pd_meta <= PD_PIN_I;
         pd_sync <= pd_meta;
         irq_meta <= PC1_PIN_I;
         irq_sync <= irq_meta;
      end
   end

   // ---------------------------------------------------------------
   // Port A pin mux
   // ---------------------------------------------------------------
   // Serial interface owns only the low four pins
   genvar g;
   generate
      for (g = 0; g < `PPI_A_W; g = g + 1) begin : g_pa
         if (g < `PPI_A_SPI_W) begin : g_spi
            assign pa_own[g] = SPI_EN_I[g];
            assign pa_out[g] = SPI_EN_I[g] ? SPI_OUT_I[g] : pa_data[g];
            assign pa_oe[g] = SPI_EN_I[g] ? SPI_OE_I[g] : pa_dir[g];
         end else begin : g_gpio
            assign pa_own[g] = 1'b0;
            assign pa_out[g] = pa_data[g];
            assign pa_oe[g] = pa_dir[g];
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Registered pin drive and readback
   // ---------------------------------------------------------------
   // Registered outputs add one cycle of latency to every pin path except D2D_IRQ_WAKE_O
   always @(posedge CLOCK_I) begin
      if (!RESET_N_I) begin
         PA_PIN_O <= 8'h00;
         PA_PIN_OE_O <= 8'h00;
         PORTA_DATA_RD_O <= 8'h00;
         PORTA_INPUT_RD_O <= 8'h00;
         SPI_IN_O <= 4'h0;
         PE_PIN_O <= 2'h0;
         PE_PIN_OE_O <= 2'h0;
         PE_PULLDOWN_O <= 2'h0;
         PORTE_DATA_RD_O <= 2'h0;
         PORTE_INPUT_RD_O <= 2'h0;
         DBG_PULLUP_O <= 1'b0;
         PC0_PIN_O <= 1'b0;
         PC0_REDUCED_O <= 1'b0;
         PC1_PULLDOWN_O <= 1'b0;
         D2D_IRQ_SYNC_O <= 1'b0;
         PD_PIN_O <= 8'h00;
         PD_PIN_OE_O <= 8'h00;
         PD_PULLDOWN_O <= 8'h00;
         PD_REDUCED_O <= 1'b0;
         D2D_DATA_IN_O <= 8'h00;
      end else begin
         PA_PIN_O <= pa_out;
         PA_PIN_OE_O <= pa_oe;
         PORTA_DATA_RD_O <= (pa_dir & pa_data) | (~pa_dir & pa_sync);
         PORTA_INPUT_RD_O <= pa_sync;
         SPI_IN_O <= pa_sync[3:0] & pa_own[3:0];
         // Oscillator takes both pins and masks the drive, the output enables and the pull-downs
         PE_PIN_O <= OSC_ACTIVE_I ? 2'h0 : pe_data;
         PE_PIN_OE_O <= OSC_ACTIVE_I ? 2'h0 : pe_dir;
         PE_PULLDOWN_O <= (OSC_ACTIVE_I || !PORTE_PULLDOWN_ENABLE_O) ? 2'h0 : ~pe_dir;
         PORTE_DATA_RD_O <= (pe_dir & pe_data) | (~pe_dir & pe_sync);
         PORTE_INPUT_RD_O <= pe_sync;
         DBG_PULLUP_O <= DEBUG_PIN_PULLUP_ENABLE_O & ~DBG_OE_I;
         PC0_PIN_O <= D2D_CLK_I;
         PC0_REDUCED_O <= PORTC_REDUCED_DRIVE_O;
         PC1_PULLDOWN_O <= 1'b1;
         D2D_IRQ_SYNC_O <= irq_sync;
         PD_PIN_O <= D2D_DATA_OUT_I;
         PD_PIN_OE_O <= {8{D2D_DATA_OE_I}};
         PD_PULLDOWN_O <= {8{~D2D_DATA_OE_I}};
         PD_REDUCED_O <= PORTD_REDUCED_DRIVE_O & D2D_DATA_OE_I;
         D2D_DATA_IN_O <= pd_sync;
      end
   end

   // ---------------------------------------------------------------
   // Stop mode wake path
   // ---------------------------------------------------------------
   // Clock is stopped in stop mode, so the raw pin must be passed through
   // Only this output is combinational: a flop would need the stopped clock
   assign D2D_IRQ_WAKE_O = STOP_MODE_I ? PC1_PIN_I : irq_sync;

endmodule

// ---- verif/ppi_pin_model.sv ----
// ---------------------------------------------
// Pins and far-side parts
// ---------------------------------------------
module ppi_pin_model #(parameter int W = 8) (
   input wire logic [W-1:0] oe_i, drv_i, ext_i, pd_i,
   input wire logic en_i,
   output logic [W-1:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Far side drives released pins only; a floating pin shows its pull or the inverse of the drive
   always_comb pin_o = oe_i & drv_i | ~oe_i & (en_i ? ext_i : ~pd_i & ~drv_i);
endmodule

// ---- verif/ppi_pins_sva.sv ----
// ---------------------------------------------
// Pin behaviour checks
// ---------------------------------------------
module ppi_pins_sva (
   input wire CLOCK_I, RESET_N_I, PORTA_DATA_WE_I, PORTA_DIR_WE_I, STOP_MODE_I, PC1_PIN_I,
   input wire D2D_IRQ_WAKE_O, PC1_PULLDOWN_O, D2D_DATA_OE_I, OSC_ACTIVE_I, DBG_OE_I, DBG_PULLUP_O,
   input wire DRIVE_WE_I, PORTC_REDUCED_DRIVE_I, PORTC_REDUCED_DRIVE_O,
   input wire [7:0] PORTA_DATA_WDATA_I, PORTA_DIR_WDATA_I, PA_PIN_I, PA_PIN_O, PA_PIN_OE_O,
   input wire [7:0] PORTA_DATA_RD_O, PORTA_INPUT_RD_O, PD_PIN_OE_O, PD_PULLDOWN_O,
   input wire [3:0] SPI_EN_I, SPI_OUT_I, SPI_OE_I, SPI_IN_O,
   input wire [1:0] PE_PULLDOWN_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);
   logic [7:0] dir_m, dat_m;
   logic [2:0] cyc;
   // Shadow of stored bits; counter keeps checks off the sync chain just after reset
   always_ff @(posedge CLOCK_I) begin
      if (!RESET_N_I) {dir_m, dat_m, cyc} <= '0;
      else begin
         if (PORTA_DIR_WE_I) dir_m <= PORTA_DIR_WDATA_I;
         if (PORTA_DATA_WE_I) dat_m <= PORTA_DATA_WDATA_I;
         if (cyc != 3'h7) cyc <= cyc + 3'h1;
      end
   end
   wire [7:0] oe_x = {dir_m[7:4], SPI_EN_I & SPI_OE_I | ~SPI_EN_I & dir_m[3:0]};
   wire [7:0] po_x = {dat_m[7:4], SPI_EN_I & SPI_OUT_I | ~SPI_EN_I & dat_m[3:0]};
   sequence s_settled;
      (cyc == 3'h7 && $stable({dir_m, dat_m, SPI_EN_I, SPI_OUT_I, SPI_OE_I, PA_PIN_I}))[*4];
   endsequence
   property p_pa_oe; s_settled |-> PA_PIN_OE_O == oe_x; endproperty
   a_pa_oe: assert property (p_pa_oe) else $error("pa enable");
   property p_pa_out; s_settled |-> (PA_PIN_O & oe_x) == (po_x & oe_x); endproperty
   a_pa_out: assert property (p_pa_out) else $error("pa drive");
   property p_pa_rd; s_settled |-> PORTA_DATA_RD_O == (dir_m & dat_m | ~dir_m & PA_PIN_I); endproperty
   a_pa_rd: assert property (p_pa_rd) else $error("pa data read");
   property p_pa_in;
      s_settled |-> PORTA_INPUT_RD_O == PA_PIN_I && SPI_IN_O == (PA_PIN_I[3:0] & SPI_EN_I);
   endproperty
   a_pa_in: assert property (p_pa_in) else $error("pa input read");
   property p_wake; STOP_MODE_I |-> D2D_IRQ_WAKE_O == PC1_PIN_I; endproperty
   a_wake: assert property (p_wake) else $error("wake path");
   property p_pc1; cyc != 3'h0 |-> PC1_PULLDOWN_O; endproperty
   a_pc1: assert property (p_pc1) else $error("irq pull");
   property p_pd; (cyc == 3'h7 && $stable(D2D_DATA_OE_I))[*3] |->
      PD_PIN_OE_O == {8{D2D_DATA_OE_I}} && PD_PULLDOWN_O == ~PD_PIN_OE_O; endproperty
   a_pd: assert property (p_pd) else $error("pd enable");
   property p_pe_pd; OSC_ACTIVE_I[*3] |-> PE_PULLDOWN_O == 2'h0; endproperty
   a_pe_pd: assert property (p_pe_pd) else $error("pe pull");
   property p_dbg; DBG_OE_I[*3] |-> !DBG_PULLUP_O; endproperty
   a_dbg: assert property (p_dbg) else $error("debug pull");
   property p_rdrv; DRIVE_WE_I |=> PORTC_REDUCED_DRIVE_O == $past(PORTC_REDUCED_DRIVE_I); endproperty
   a_rdrv: assert property (p_rdrv) else $error("drive bit");
endmodule
bind ppi_port_pins ppi_pins_sva chk (.*);

// ---- verif/ppi_port_pins_bench.sv ----
// ---------------------------------------------
// Bench
// ---------------------------------------------
module ppi_port_pins_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK_I = '0, RESET_N_I = '0, PORTA_DATA_WE_I = '0, PORTA_DIR_WE_I = '0, PORTE_DATA_WE_I = '0;
   logic PORTE_DIR_WE_I = '0, OSC_ACTIVE_I = '0, PULL_WE_I = '0, DEBUG_PIN_PULLUP_ENABLE_I = '0, d_en = '1;
   logic PORTE_PULLDOWN_ENABLE_I = '0, DRIVE_WE_I = '0, PORTC_REDUCED_DRIVE_I = '0, PORTD_REDUCED_DRIVE_I = '0;
   logic DBG_OE_I = '0, D2D_CLK_I = '0, PC1_PIN_I = '0, STOP_MODE_I = '0, D2D_DATA_OE_I = '0;
   logic [7:0] PORTA_DATA_WDATA_I = '0, PORTA_DIR_WDATA_I = '0, D2D_DATA_OUT_I = '0, a_ext = '0, d_ext = '0;
   logic [3:0] SPI_EN_I = '0, SPI_OUT_I = '0, SPI_OE_I = '0;
   logic [1:0] PORTE_DATA_WDATA_I = '0, PORTE_DIR_WDATA_I = '0, e_ext = 2'h1;
   wire [7:0] PA_PIN_I, PA_PIN_O, PA_PIN_OE_O, PORTA_DATA_RD_O, PORTA_INPUT_RD_O, PD_PIN_I, PD_PIN_O;
   wire [7:0] PD_PIN_OE_O, PD_PULLDOWN_O, D2D_DATA_IN_O;
   wire [3:0] SPI_IN_O;
   wire [1:0] PE_PIN_I, PE_PIN_O, PE_PIN_OE_O, PE_PULLDOWN_O, PORTE_DATA_RD_O, PORTE_INPUT_RD_O;
   wire DEBUG_PIN_PULLUP_ENABLE_O, PORTE_PULLDOWN_ENABLE_O, PORTC_REDUCED_DRIVE_O, PORTD_REDUCED_DRIVE_O;
   wire DBG_PULLUP_O, PC0_PIN_O, PC0_REDUCED_O, PC1_PULLDOWN_O, D2D_IRQ_SYNC_O, D2D_IRQ_WAKE_O, PD_REDUCED_O;
   int failures = 0, n_tests = 0, cycles = 0;
   typedef struct packed {
      logic [7:0] dir, dat;
      logic [3:0] sen, sout, soe;
      logic [7:0] ext, oe, po, rd, inp;
   } ppi_row_t;
   // Direction, data, serial use and far-side level beside expected enable, drive, data and input reads
   ppi_row_t rows [4] = '{'{8'h00, 8'hA5, 4'h0, 4'h0, 4'h0, 8'h3C, 8'h00, 8'h00, 8'h3C, 8'h3C},
      '{8'hFF, 8'hA5, 4'h0, 4'h0, 4'h0, 8'h3C, 8'hFF, 8'hA5, 8'hA5, 8'hA5},
      '{8'hF0, 8'h96, 4'h0, 4'h0, 4'h0, 8'h0F, 8'hF0, 8'h90, 8'h9F, 8'h9F},
      '{8'h0F, 8'h5A, 4'hF, 4'h6, 4'h3, 8'hC3, 8'h03, 8'h02, 8'hCA, 8'hC2}};
   ppi_port_pins dut (.*);
   ppi_pin_model #(.W(8)) ma (.oe_i(PA_PIN_OE_O), .drv_i(PA_PIN_O), .ext_i(a_ext), .pd_i(8'h00), .en_i(1'h1),
      .pin_o(PA_PIN_I));
   ppi_pin_model #(.W(8)) md (.oe_i(PD_PIN_OE_O), .drv_i(PD_PIN_O), .ext_i(d_ext), .pd_i(PD_PULLDOWN_O),
      .en_i(d_en), .pin_o(PD_PIN_I));
   ppi_pin_model #(.W(2)) me (.oe_i(PE_PIN_OE_O), .drv_i(PE_PIN_O), .ext_i(e_ext), .pd_i(PE_PULLDOWN_O),
      .en_i(1'h1), .pin_o(PE_PIN_I));
   always #50 CLOCK_I = ~CLOCK_I;
   // Hang guard, far above the 67 cycles the run needs
   always @(posedge CLOCK_I) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d wrong %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   // Inputs move a fixed 5 ns after the edge so no race with sampling
   task automatic tick(int n);
      repeat (n) @(posedge CLOCK_I);
      #5;
   endtask
   initial begin
      tick(8);
      RESET_N_I = 1'h1;
      tick(4);
      chk("pa oe rst", 8'h00, PA_PIN_OE_O);
      chk("pull rst", 8'h07, {DBG_PULLUP_O, DEBUG_PIN_PULLUP_ENABLE_O, PORTE_PULLDOWN_ENABLE_O});
      chk("pe pulls", 8'h03, PE_PULLDOWN_O);
      // Clearing both pull bits must release the pulls, then they are restored
      {PULL_WE_I, DEBUG_PIN_PULLUP_ENABLE_I, PORTE_PULLDOWN_ENABLE_I} = 3'h4;
      tick(2);
      chk("pull off", 8'h00, {DBG_PULLUP_O, PORTE_PULLDOWN_ENABLE_O, PE_PULLDOWN_O});
      {DEBUG_PIN_PULLUP_ENABLE_I, PORTE_PULLDOWN_ENABLE_I} = 2'h3;
      tick(1);
      PULL_WE_I = 1'h0;
      foreach (rows[i]) begin
         {SPI_EN_I, SPI_OUT_I, SPI_OE_I, a_ext} = {rows[i].sen, rows[i].sout, rows[i].soe, rows[i].ext};
         PORTA_DATA_WDATA_I = rows[i].dat;
         PORTA_DATA_WE_I = 1'h1;
         tick(1);
         PORTA_DATA_WE_I = 1'h0; // data before direction
         PORTA_DIR_WDATA_I = rows[i].dir;
         PORTA_DIR_WE_I = 1'h1;
         tick(1);
         PORTA_DIR_WE_I = 1'h0;
         tick(6);
         chk("pa oe", rows[i].oe, PA_PIN_OE_O);
         chk("pa out", rows[i].po, PA_PIN_O & PA_PIN_OE_O);
         chk("pa data", rows[i].rd, PORTA_DATA_RD_O);
         chk("pa in", rows[i].inp, PORTA_INPUT_RD_O);
         chk("spi in", rows[i].inp[3:0] & rows[i].sen, SPI_IN_O);
      end
      OSC_ACTIVE_I = 1'h1;
      tick(3);
      chk("pe osc", 8'h04, {PORTE_PULLDOWN_ENABLE_O, PE_PULLDOWN_O});
      OSC_ACTIVE_I = 1'h0;
      {PORTE_DATA_WDATA_I, PORTE_DATA_WE_I, DBG_OE_I} = {2'h2, 1'h1, 1'h1};
      tick(1);
      {PORTE_DATA_WE_I, PORTE_DIR_WDATA_I, PORTE_DIR_WE_I} = {1'h0, 2'h3, 1'h1};
      tick(1);
      PORTE_DIR_WE_I = 1'h0;
      {DRIVE_WE_I, PORTC_REDUCED_DRIVE_I, PORTD_REDUCED_DRIVE_I} = 3'h7;
      {D2D_DATA_OE_I, D2D_DATA_OUT_I, D2D_CLK_I} = {1'h1, 8'h5A, 1'h1};
      tick(1);
      DRIVE_WE_I = 1'h0;
      tick(4);
      chk("pe out", 8'hE2, {PE_PIN_OE_O, PE_PIN_O, PE_PULLDOWN_O, PORTE_DATA_RD_O});
      chk("pe in", 8'h02, PORTE_INPUT_RD_O);
      chk("dbg pull", 8'h00, DBG_PULLUP_O);
      chk("pc0", 8'h0F, {PORTD_REDUCED_DRIVE_O, PC0_PIN_O, PC0_REDUCED_O, PD_REDUCED_O});
      chk("pd out", 8'h5A, PD_PIN_O & PD_PIN_OE_O);
      chk("pd in", 8'h5A, D2D_DATA_IN_O);
      {D2D_DATA_OE_I, d_en} = 2'h0;
      tick(6);
      chk("pd pull", 8'h00, D2D_DATA_IN_O);
      {STOP_MODE_I, PC1_PIN_I} = 2'h3;
      #1;
      chk("wake", 8'h01, D2D_IRQ_WAKE_O);
      tick(4);
      chk("irq sync", 8'h01, D2D_IRQ_SYNC_O);
      print_verdict();
   end
endmodule
